// file: pkg/nfcf_pkg.sv
// constants, codes and carriers for the flash command front end and read path
package nfcf_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 4 * DATA_W;

    // command codes seen on the low data byte of a write cycle
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT  = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
    localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
    localparam logic [7:0] CMD_LOCK        = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN    = 8'h2F;
    localparam logic [7:0] CMD_PROT_SETUP  = 8'hC0;
    localparam logic [7:0] CMD_CONFIG_SET  = 8'h03;

    // status_word bit positions
    localparam int SW_READY      = 7;
    localparam int SW_ERASE_SUSP = 6;
    localparam int SW_ERASE_ERR  = 5;
    localparam int SW_PROG_ERR   = 4;
    localparam int SW_PROG_SUSP  = 2;

    // read_config_word fields and reset value
    localparam int              RC_MODE     = 15;
    localparam int              RC_LAT_HI   = 13;
    localparam int              RC_LAT_LO   = 11;
    localparam int              RC_WAIT_POL = 10;
    localparam int              RC_BL_HI    = 2;
    localparam logic [15:0]     RC_RESET    = 16'hBFCF;
    localparam logic [2:0]      BL_4        = 3'h1;
    localparam logic [2:0]      BL_8        = 3'h2;
    localparam logic [2:0]      BL_16       = 3'h3;
    localparam logic [4:0]      BL_4_WORDS  = 5'h04;
    localparam logic [4:0]      BL_8_WORDS  = 5'h08;
    localparam logic [4:0]      BL_16_WORDS = 5'h10;

    typedef enum logic [1:0] {
        CMD_IDLE    = 2'b00,
        CMD_ERASE_S = 2'b01,
        CMD_LOCK_S  = 2'b11,
        CMD_PROT_S  = 2'b10
    } nfcf_cmd_st_t;

    typedef enum logic [1:0] {
        RD_ARRAY  = 2'b00,
        RD_STATUS = 2'b01,
        RD_IDENT  = 2'b11,
        RD_QUERY  = 2'b10
    } nfcf_rd_st_t;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_LAT  = 2'b01,
        B_DATA = 2'b11,
        B_DONE = 2'b10
    } nfcf_burst_st_t;

    typedef enum logic [1:0] {
        LK_LOCK     = 2'b00,
        LK_UNLOCK   = 2'b01,
        LK_LOCKDOWN = 2'b10
    } nfcf_lock_t;

    // control pins, all active low except the burst clock
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic address_valid_n;
        logic rst_n;
        logic burst_clk;
    } nfcf_pins_t;

    localparam nfcf_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nfcf_bus_t;
endpackage

// file: rtl/nfcf_sync2.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module nfcf_sync2 #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// file: rtl/nfcf_front.sv
// command decoder, status word, read configuration and read path of the flash
// Operation
// - erase setup 0x20 then confirm 0xD0 starts erase of the confirm-cycle block
// - anything but confirm after erase setup sets status bits 4,5 and status read
// - during a running erase only read-status and suspend are accepted
// - status shown refreshes on ce/oe toggle async, ce/address-valid toggle sync
// - 0xB0 suspends; status shows program or erase suspended plus ready
// - suspended state persists until resume (0xD0) or until the reset input is asserted
// - 0xD0 while suspended resumes the suspended operation
// - after 0x60, 0x01 locks, 0xD0 unlocks, 0x2F locks down the block
// - other second cycle after lock setup, except 0x03, sets status bits 4 and 5
// - unlock of a locked-down block leaves protection unchanged
// - after 0xC0 the next cycle's address and data start protection program
// - after 0x60 a second cycle other than 0x01, 0xD0, 0x2F or 0x03 flags sequence error
// - valid config cycle loads address bits 15..0 and returns to array read
// - after reset: asynchronous page mode and array read state
// - four read states, changed by the matching read command, erase errors, erase start or config
// - asynchronous page reads happen only while config bit 15 is set
// - async mode keeps wait deasserted and ignores the burst clock
// - async access fetches a four-word page; address bits 1..0 pick the word
// - burst address latches on address-valid rise or clock edge while low
// - first word after programmed latency, later words on following edges
// - non-array sync reads repeat one word until burst length delivered
// - config bit 15 clear selects burst reads, set selects page reads
// - engine only sets error bits; 0x50 clears them
// - 0x70 selects status read on the low data byte
`timescale 1ns/1ps
module nfcf_front
    import nfcf_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire nfcf_pins_t           pins,
    input  wire nfcf_bus_t            bus_in,
    output logic [DATA_W-1:0]         dq_out,
    output logic                      dq_oe,
    output logic                      wait_out,
    output logic                      wait_oe,
    output logic                      array_rd,
    output logic [ADDR_W-3:0]         array_page_addr,
    input  wire logic [PAGE_W-1:0]    array_page,
    input  wire logic [DATA_W-1:0]    special_data,
    output logic                      erase_start,
    output logic                      suspend_req,
    output logic                      resume_req,
    input  wire logic                 eng_erase_busy,
    input  wire logic                 eng_prog_busy,
    input  wire logic                 eng_erase_fail,
    input  wire logic                 eng_prog_fail,
    output logic                      lock_req,
    output nfcf_lock_t                lock_action,
    input  wire logic                 lockdown_in,
    output logic                      prot_req,
    output logic [ADDR_W-1:0]         cmd_addr,
    output logic [DATA_W-1:0]         cmd_data,
    output logic [7:0]                status_word,
    output logic [15:0]               read_config_word,
    output nfcf_rd_st_t               read_state
);
    nfcf_pins_t     pins_s, pins_q;
    nfcf_bus_t      bus_s;
    nfcf_cmd_st_t   cmd_st_q, cmd_st_d;
    nfcf_rd_st_t    rd_st_q, rd_st_d;
    nfcf_burst_st_t b_st_q, b_st_d;
    logic [15:0]       rcr_q;
    logic              erase_err_q, prog_err_q, susp_erase_q, susp_prog_q;
    logic [7:0]        shown_q;
    logic [ADDR_W-1:0] addr_lat_q, baddr_q, cmd_addr_q;
    logic [DATA_W-1:0] cmd_data_q, dq_q;
    logic [ADDR_W-3:0] page_tag_q;
    logic [PAGE_W-1:0] page_q;
    logic              rd_q, rd_pend_q, dq_oe_q;
    logic              erase_start_q, suspend_q, resume_q, lock_q, prot_q;
    nfcf_lock_t        lock_act_q;
    logic [2:0]        lat_q;
    logic [4:0]        bcnt_q;

    // every pin passes two flops before any logic looks at it
    nfcf_sync2 #(.W($bits(nfcf_pins_t)), .RST_VAL(PINS_IDLE)) u_sync_pins (
        .clk  (clk),
        .srst (srst),
        .d    (pins),
        .q    (pins_s)
    );
    nfcf_sync2 #(.W($bits(nfcf_bus_t)), .RST_VAL('0)) u_sync_bus (
        .clk  (clk),
        .srst (srst),
        .d    (bus_in),
        .q    (bus_s)
    );

    // previous pin levels; idle reset value so no false edge follows reset
    always_ff @(posedge clk) begin
        if (srst) begin
            pins_q <= PINS_IDLE;
        end else begin
            pins_q <= pins_s;
        end
    end

    // edges of the synchronised pins; the reset pin acts like srst
    wire rst_all   = srst | ~pins_s.rst_n;
    wire ce_low    = ~pins_s.ce_n;
    wire ce_fall   = ~pins_s.ce_n & pins_q.ce_n;
    wire ce_tog    = pins_s.ce_n ^ pins_q.ce_n;
    wire oe_tog    = pins_s.oe_n ^ pins_q.oe_n;
    wire adv_tog   = pins_s.address_valid_n ^ pins_q.address_valid_n;
    wire adv_rise  = pins_s.address_valid_n & ~pins_q.address_valid_n;
    wire we_rise   = pins_s.we_n & ~pins_q.we_n & ce_low;
    wire bclk_rise = pins_s.burst_clk & ~pins_q.burst_clk;
    wire async_md  = rcr_q[RC_MODE];
    wire rd_active = ce_low & ~pins_s.oe_n & pins_s.we_n;

    // command filter: a running operation only hears status read and suspend
    wire [7:0] code      = bus_s.data[7:0];
    wire       suspended = susp_erase_q | susp_prog_q;
    wire       busy_run  = (eng_erase_busy | eng_prog_busy) & ~suspended;
    wire       cmd_ok    = ~busy_run | code == CMD_SUSPEND | code == CMD_READ_STATUS;
    wire       wr        = we_rise & cmd_ok;
    wire       idle_wr   = wr & cmd_st_q == CMD_IDLE;
    wire       erase_2nd = wr & cmd_st_q == CMD_ERASE_S;
    wire       lock_2nd  = wr & cmd_st_q == CMD_LOCK_S;

    // second-cycle decode
    wire lk_code   = code == CMD_LOCK | code == CMD_CONFIRM | code == CMD_LOCKDOWN;
    wire go_erase  = erase_2nd & code == CMD_CONFIRM;
    wire err_erase = erase_2nd & code != CMD_CONFIRM;
    wire err_lock  = lock_2nd & ~lk_code & code != CMD_CONFIG_SET;
    wire seq_err   = err_erase | err_lock;
    wire go_lock   = lock_2nd & lk_code & ~(code == CMD_CONFIRM & lockdown_in);
    wire go_cfg    = lock_2nd & code == CMD_CONFIG_SET;
    wire go_prot   = wr & cmd_st_q == CMD_PROT_S;
    wire go_susp   = idle_wr & code == CMD_SUSPEND & busy_run;
    wire go_resume = idle_wr & code == CMD_CONFIRM & suspended;
    wire go_clear  = idle_wr & code == CMD_CLEAR_STAT;
    wire [1:0] lk_sel = code == CMD_LOCK ? LK_LOCK : code == CMD_LOCKDOWN ? LK_LOCKDOWN : LK_UNLOCK;

    // setup codes open a two-cycle command; any second cycle closes it
    assign cmd_st_d = ~wr                          ? cmd_st_q :
                      cmd_st_q != CMD_IDLE         ? CMD_IDLE :
                      code == CMD_ERASE_SETUP      ? CMD_ERASE_S :
                      code == CMD_LOCK_SETUP       ? CMD_LOCK_S :
                      code == CMD_PROT_SETUP       ? CMD_PROT_S : CMD_IDLE;

    // read state moves only on read commands, erase errors, erase start or config
    assign rd_st_d = (err_erase | go_erase)                  ? RD_STATUS :
                     go_cfg                                  ? RD_ARRAY :
                     ~idle_wr                                ? rd_st_q :
                     code == CMD_READ_ARRAY                  ? RD_ARRAY :
                     code == CMD_READ_STATUS                 ? RD_STATUS :
                     code == CMD_READ_IDENT                  ? RD_IDENT :
                     code == CMD_READ_QUERY                  ? RD_QUERY : rd_st_q;

    // ready also while suspended, since the engine is parked
    assign status_word = {~(eng_erase_busy | eng_prog_busy) | suspended, susp_erase_q, erase_err_q,
                          prog_err_q, 1'b0, susp_prog_q, 2'b00};

    // command and status state
    always_ff @(posedge clk) begin
        if (rst_all) begin
            cmd_st_q <= CMD_IDLE;
            rd_st_q  <= RD_ARRAY;
            rcr_q    <= RC_RESET;
        end else begin
            cmd_st_q <= cmd_st_d;
            rd_st_q  <= rd_st_d;
            if (go_cfg) begin
                rcr_q <= bus_s.addr[15:0];
            end
        end
    end

    // error bits: a set in the clearing cycle wins over the clear
    always_ff @(posedge clk) begin
        if (rst_all) begin
            erase_err_q <= 1'b0;
            prog_err_q  <= 1'b0;
        end else begin
            erase_err_q <= (erase_err_q & ~go_clear) | seq_err | eng_erase_fail;
            prog_err_q  <= (prog_err_q & ~go_clear) | seq_err | eng_prog_fail;
        end
    end

    // suspend flags leave only by resume or by the reset input
    always_ff @(posedge clk) begin
        if (rst_all) begin
            susp_erase_q <= 1'b0;
            susp_prog_q  <= 1'b0;
        end else if (go_susp) begin
            susp_erase_q <= eng_erase_busy;
            susp_prog_q  <= ~eng_erase_busy;
        end else if (go_resume) begin
            susp_erase_q <= 1'b0;
            susp_prog_q  <= 1'b0;
        end
    end

    // one-cycle requests to the engine, lock store and protection logic
    always_ff @(posedge clk) begin
        if (rst_all) begin
            erase_start_q <= 1'b0;
            suspend_q     <= 1'b0;
            resume_q      <= 1'b0;
            lock_q        <= 1'b0;
            prot_q        <= 1'b0;
            lock_act_q    <= LK_LOCK;
            cmd_addr_q    <= '0;
            cmd_data_q    <= '0;
        end else begin
            erase_start_q <= go_erase;
            suspend_q     <= go_susp;
            resume_q      <= go_resume;
            lock_q        <= go_lock;
            prot_q        <= go_prot;
            if (go_lock) begin
                lock_act_q <= nfcf_lock_t'(lk_sel);
            end
            if (go_erase | go_lock | go_prot) begin
                cmd_addr_q <= bus_s.addr;
                cmd_data_q <= bus_s.data;
            end
        end
    end

    // shown status snapshot; a refresh needs a toggle, so polling alone shows old data
    wire refresh = async_md ? (ce_tog | oe_tog) : (ce_tog | adv_tog);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            shown_q <= '0;
        end else if (refresh) begin
            shown_q <= status_word;
        end
    end

    // address is transparent while address valid is low, held once it rises
    wire [ADDR_W-1:0] addr_cur = pins_s.address_valid_n ? addr_lat_q : bus_s.addr;

    // burst control; bursts are linear and ignore the wrap option
    wire [4:0] bl_words = rcr_q[RC_BL_HI:0] == BL_4  ? BL_4_WORDS :
                          rcr_q[RC_BL_HI:0] == BL_8  ? BL_8_WORDS :
                          rcr_q[RC_BL_HI:0] == BL_16 ? BL_16_WORDS : 5'h00;
    wire b_latch = ~async_md & ce_low & b_st_q == B_IDLE
                   & (adv_rise | (bclk_rise & ~pins_s.address_valid_n));
    wire b_edge  = bclk_rise & ce_low;
    wire b_emit  = b_edge & ((b_st_q == B_LAT & lat_q <= 3'h1) | b_st_q == B_DATA);
    wire b_last  = bl_words != 5'h00 & bcnt_q + 5'h01 == bl_words;
    wire is_arr  = rd_st_q == RD_ARRAY;
    wire b_step  = b_emit & is_arr;

    assign b_st_d = ~ce_low ? B_IDLE :
                    b_latch ? B_LAT :
                    b_emit  ? (b_last ? B_DONE : B_DATA) : b_st_q;

    always_ff @(posedge clk) begin
        if (rst_all) begin
            b_st_q     <= B_IDLE;
            lat_q      <= '0;
            bcnt_q     <= '0;
            baddr_q    <= '0;
            addr_lat_q <= '0;
        end else begin
            b_st_q <= b_st_d;
            if (~pins_s.address_valid_n) begin
                addr_lat_q <= bus_s.addr;
            end
            if (b_latch) begin
                lat_q   <= rcr_q[RC_LAT_HI:RC_LAT_LO];
                bcnt_q  <= '0;
                baddr_q <= addr_cur;
            end else if (b_edge & b_st_q == B_LAT) begin
                lat_q <= lat_q - 3'h1;
            end
            if (b_emit) begin
                bcnt_q <= bcnt_q + 5'h01;
            end
            if (b_step) begin
                baddr_q <= baddr_q + ADDR_W'(1);
            end
        end
    end

    // page fetch: async on chip select or page change, sync at latch and page rollover
    wire a_fetch = async_md & ce_low & (ce_fall | addr_cur[ADDR_W-1:2] != page_tag_q);
    wire s_roll  = b_step & baddr_q[1:0] == 2'b11;
    wire fetch   = a_fetch | b_latch | s_roll;
    wire [ADDR_W-3:0] f_page = s_roll ? baddr_q[ADDR_W-1:2] + (ADDR_W-2)'(1) : addr_cur[ADDR_W-1:2];

    always_ff @(posedge clk) begin
        if (rst_all) begin
            rd_q       <= 1'b0;
            rd_pend_q  <= 1'b0;
            page_tag_q <= '0;
            page_q     <= '0;
        end else begin
            rd_q      <= fetch;
            rd_pend_q <= rd_q;
            if (fetch) begin
                page_tag_q <= f_page;
            end
            if (rd_pend_q) begin
                page_q <= array_page;
            end
        end
    end

    // data word selection; non-array reads repeat one word every edge
    wire [1:0]        w_idx   = async_md ? addr_cur[1:0] : baddr_q[1:0];
    wire [DATA_W-1:0] page_w  = page_q[16*w_idx +: 16];
    wire [DATA_W-1:0] nonarr  = rd_st_q == RD_STATUS ? {8'h00, shown_q} : special_data;
    wire [DATA_W-1:0] rd_word = is_arr ? page_w : nonarr;
    wire [DATA_W-1:0] dq_d    = async_md ? rd_word : (b_emit ? rd_word : dq_q);
    wire              waiting = ~async_md & (b_st_q == B_LAT | b_st_q == B_IDLE);

    always_ff @(posedge clk) begin
        if (rst_all) begin
            dq_q    <= '0;
            dq_oe_q <= 1'b0;
        end else begin
            dq_q    <= dq_d;
            dq_oe_q <= rd_active;
        end
    end

    // outputs; wait sits at its inactive level in page mode
    assign dq_out           = dq_q;
    assign dq_oe            = dq_oe_q;
    assign wait_out         = rcr_q[RC_WAIT_POL] ? waiting : ~waiting;
    assign wait_oe          = ce_low;
    assign array_rd         = rd_q;
    assign array_page_addr  = page_tag_q;
    assign erase_start      = erase_start_q;
    assign suspend_req      = suspend_q;
    assign resume_req       = resume_q;
    assign lock_req         = lock_q;
    assign lock_action      = lock_act_q;
    assign prot_req         = prot_q;
    assign cmd_addr         = cmd_addr_q;
    assign cmd_data         = cmd_data_q;
    assign read_config_word = rcr_q;
    assign read_state       = rd_st_q;

    // checks
    property p_erase_seq;
        @(posedge clk) disable iff (rst_all)
        err_erase |=> erase_err_q && prog_err_q && rd_st_q == RD_STATUS;
    endproperty
    a_erase_seq: assert property (p_erase_seq) else $error("erase sequence error not flagged");

    property p_busy_filter;
        @(posedge clk) disable iff (rst_all)
        we_rise && busy_run && code != CMD_SUSPEND && code != CMD_READ_STATUS
        |=> $stable(cmd_st_q) && $stable(rd_st_q) && !erase_start;
    endproperty
    a_busy_filter: assert property (p_busy_filter) else $error("command taken while busy");

    property p_suspend;
        @(posedge clk) disable iff (rst_all)
        go_susp |=> suspend_req && status_word[SW_READY] && (status_word[SW_ERASE_SUSP] || status_word[SW_PROG_SUSP]);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not shown in status");

    property p_susp_hold;
        @(posedge clk) disable iff (rst_all)
        susp_erase_q && !go_resume |=> susp_erase_q;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("erase suspend lost");

    property p_resume;
        @(posedge clk) disable iff (rst_all)
        go_resume |=> resume_req && !suspended ##1 !resume_req;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not one pulse");

    property p_lockdown;
        @(posedge clk) disable iff (rst_all)
        lock_2nd && code == CMD_CONFIRM && lockdown_in |=> !lock_req;
    endproperty
    a_lockdown: assert property (p_lockdown) else $error("locked-down block unlocked");

    property p_config;
        @(posedge clk) disable iff (rst_all)
        go_cfg |=> read_config_word == $past(bus_s.addr[15:0]) && read_state == RD_ARRAY;
    endproperty
    a_config: assert property (p_config) else $error("config word not loaded");

    property p_pin_reset;
        @(posedge clk) disable iff (srst)
        !pins_s.rst_n |=> read_config_word == RC_RESET && read_state == RD_ARRAY && !suspended;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset state wrong");

    property p_async_wait;
        @(posedge clk) disable iff (rst_all)
        async_md && ce_low |-> wait_out == ~rcr_q[RC_WAIT_POL] && b_st_q == B_IDLE;
    endproperty
    a_async_wait: assert property (p_async_wait) else $error("wait asserted in page mode");

    property p_clear;
        @(posedge clk) disable iff (rst_all)
        go_clear && !eng_erase_fail && !eng_prog_fail |=> !status_word[SW_ERASE_ERR] && !status_word[SW_PROG_ERR];
    endproperty
    a_clear: assert property (p_clear) else $error("error bits not cleared");

    property p_status_cmd;
        @(posedge clk) disable iff (rst_all)
        idle_wr && code == CMD_READ_STATUS |=> read_state == RD_STATUS;
    endproperty
    a_status_cmd: assert property (p_status_cmd) else $error("status read not selected");
endmodule

// file: test/nfcf_eng_model.sv
// far-side model: erase engine level and four-word array page
`timescale 1ns/1ps
module nfcf_eng_model
    import nfcf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        erase_start,
    input  wire logic [21:0] array_page_addr,
    output logic [63:0]      array_page,
    output logic             eng_erase_busy
);
    // each word holds its own address, so a wrong word pick shows at once
    assign array_page = {4{array_page_addr[13:0], 2'h0}} | 64'h0003_0002_0001_0000;
    // erase outlasts the run on purpose: the front end must keep refusing
    always_ff @(posedge clk)
        eng_erase_busy <= ~srst & (eng_erase_busy | erase_start);
endmodule

// file: test/tb_nfcf_front.sv
// self-checking bench for the flash command front end and read path
`timescale 1ns/1ps
module tb_nfcf_front;
    import nfcf_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, lockdown_in = 1'b0;
    logic        erase_start, lock_req, eng_erase_busy;
    nfcf_pins_t  pins = PINS_IDLE;
    nfcf_bus_t   bus_in = '0;
    logic [15:0] dq_out, read_config_word;
    logic [21:0] array_page_addr;
    logic [63:0] array_page;
    logic [7:0]  status_word;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_data;
    nfcf_rd_st_t read_state;
    nfcf_lock_t  lock_action;
    int          n_fail = 0, checks_done = 0, n_lk = 0;
    always #25 clk = ~clk;
    // lock pulses stand one cycle, so count them here
    always @(posedge clk) n_lk += int'(lock_req === 1'b1);
    nfcf_front i_nfcf_front (.clk, .srst, .pins, .bus_in, .dq_out, .dq_oe(), .wait_out(), .wait_oe(), .array_rd(),
        .array_page_addr, .array_page, .special_data(16'h5a5a), .erase_start, .suspend_req(), .resume_req(),
        .eng_erase_busy, .eng_prog_busy(1'b0), .eng_erase_fail(1'b0), .eng_prog_fail(1'b0), .lock_req, .prot_req(),
        .lock_action, .lockdown_in, .cmd_addr, .cmd_data, .status_word, .read_config_word, .read_state);
    nfcf_eng_model i_nfcf_eng_model (.clk, .srst, .erase_start, .array_page_addr, .array_page, .eng_erase_busy);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
        n_fail += int'(got !== exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write cycle; we held low 3 clocks and high 5 clocks so the synchronisers see it
    task automatic wr(input logic [15:0] d, input logic [23:0] a = 24'h00_0000);
        @(posedge clk) #5;
        pins   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        bus_in = '{a, d};
        repeat (3) @(posedge clk) #5;
        pins.we_n = 1'b1;
        repeat (5) @(posedge clk) #5;
        pins = PINS_IDLE;
    endtask
    task automatic t_lock();
        wr(CMD_LOCK_SETUP);
        wr(CMD_LOCKDOWN, 24'h34_0000);
        chk(lock_action, LK_LOCKDOWN);
        lockdown_in = 1'b1;
        wr(CMD_LOCK_SETUP);
        wr(CMD_CONFIRM, 24'h34_0000);
        chk(n_lk, 1);
    endtask
    // async page read; address valid held low for the whole cycle
    task automatic rd(input logic [23:0] a);
        @(posedge clk) #5;
        pins        = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        bus_in.addr = a;
        repeat (8) @(posedge clk) #5;
        pins = PINS_IDLE;
    endtask
    task automatic t_read();
        wr(CMD_READ_ARRAY);
        rd(24'h00_0106);
        chk(dq_out, 16'h0106);
    endtask
    task automatic t_cfg();
        wr(CMD_LOCK_SETUP);
        wr(CMD_READ_ARRAY);
        chk({status_word, read_state}, {8'hb0, RD_ARRAY});
        wr(CMD_CLEAR_STAT);
        chk(status_word, 8'h80);
        wr(CMD_READ_STATUS);
        rd(24'h00_0000);
        chk(dq_out, 16'h0080);
        wr(CMD_LOCK_SETUP);
        wr(CMD_CONFIG_SET, 24'h00_bfc1);
        chk({read_config_word, read_state}, {16'hbfc1, RD_ARRAY});
        wr(CMD_PROT_SETUP);
        wr(16'h1234, 24'h00_0080);
        chk(cmd_addr, 24'h00_0080);
        chk(cmd_data, 16'h1234);
    endtask
    task automatic t_erase();
        wr(CMD_ERASE_SETUP);
        wr(CMD_READ_IDENT);
        chk(status_word, 8'hb0);
        wr(CMD_ERASE_SETUP);
        wr(CMD_CONFIRM, 24'h12_0000);
        wr(CMD_READ_IDENT);
        chk(read_state, RD_STATUS);
        chk(cmd_addr, 24'h12_0000);
        wr(CMD_SUSPEND, 24'h00_0abc);
        chk(status_word, 8'hf0);
        wr(CMD_CONFIRM, 24'h00_0555);
        chk(status_word, 8'h30);
    endtask
    initial begin
        repeat (12) @(posedge clk) #5;
        srst = 1'b0;
        chk({read_config_word, read_state}, {RC_RESET, RD_ARRAY});
        t_lock();
        t_read();
        t_cfg();
        t_erase();
        test_done();
    end
endmodule
